// ### verilog/video_output_stage.sv
// video output stage: tristate, test patterns, PAL+ line handling, sync latch
// Functional notes
// - register control can tristate every data/sync pin
// - enable pin low tristates data outputs immediately
// - test mode substitutes ramps, flat field, colour bar
// - helper-line samples use the signed chroma-style scaling; the signalling part of reference lines uses the luma path
// - comb filter off on every helper line
// - core lines carry scaled composite on luma
// - helper window lines carry demodulated helper on luma
// - reference lines treat signalling part separately
// - component levels black 16, chroma 128+-112
// - composite levels black 64, amplitude 149
// - helper signed +-109; signalling level 68, no chroma
// - helper black and burst around 128, amplitude 19
// - sync outputs latched on line-locked clock
// - vertical output timing lags input three lines
`timescale 1ns/1ps
`default_nettype none
module video_output_stage
  import vout_pkg::*;
(
  // clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       NRST,
  // processed input stream
  input  wire logic [7:0] IN_LUMA,
  input  wire logic [7:0] IN_CHROMA,
  input  wire logic [7:0] IN_COMPOSITE,
  input  wire logic [7:0] IN_HELPER,
  input  wire logic       IN_WSS_PART,
  input  wire logic       IN_HSYNC,
  input  wire logic       IN_VSYNC,
  input  wire logic       IN_VALID,
  output logic            IN_READY,
  // configuration
  input  wire logic       DATA_TRISTATE,
  input  wire logic       SYNC_TRISTATE,
  input  wire logic       PIXEL_OUTPUT_ENABLE_PIN,
  input  wire logic       TEST_MODE,
  input  wire logic [1:0] TEST_PATTERN,
  input  wire logic       PALPLUS_MODE,
  input  wire logic       COMPOSITE_FMT,
  input  wire logic       CHROMA_SIGNED,
  // comb filter control
  output logic            COMB_ADAPT_EN,
  // pins toward the back-end
  output logic [7:0]      Y_OUT,
  output logic            Y_OE,
  output logic [7:0]      C_OUT,
  output logic            C_OE,
  output logic            HSYNC_OUT,
  output logic            VSYNC_OUT,
  output logic            SYNC_OE,
  output logic            OUT_VALID
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic in_range(input logic [9:0] n, input logic [9:0] lo,
                                    input logic [9:0] hi);
    return (n >= lo) && (n <= hi);
  endfunction

  // map a full-range value onto black..black+ampl, no clamping
  function automatic logic [7:0] scale_luma(input logic [7:0] v,
                                            input logic [7:0] black,
                                            input logic [7:0] ampl);
    logic [15:0] p;
    p = 16'(v) * 16'(ampl);
    return 8'(16'(black) + (p >> 8));
  endfunction

  // offset binary sample to signed +-ampl; shared by chroma, helper and reference burst
  function automatic logic [7:0] scale_signed(input logic [7:0] v,
                                              input logic [7:0] ampl);
    logic signed [15:0] s;
    s = 16'(signed'({1'b0, v}) - signed'({1'b0, CHROMA_MID})) * signed'(16'(ampl));
    return 8'(s >>> 7);
  endfunction

  function automatic logic [7:0] scale_chroma(input logic [7:0] v,
                                              input logic       sgn);
    logic [7:0] s;
    s = scale_signed(v, CHROMA_AMPL);
    return sgn ? s : s + CHROMA_MID;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input buffer

  sample_t    fifo_in;
  sample_t    cur;
  logic       cur_valid;
  logic [SAMPLE_W-1:0] fifo_out_bits;

  assign fifo_in = '{luma: IN_LUMA, chroma: IN_CHROMA, composite: IN_COMPOSITE,
                     helper: IN_HELPER, wss_part: IN_WSS_PART,
                     hsync: IN_HSYNC, vsync: IN_VSYNC};
  assign cur = sample_t'(fifo_out_bits);

  // a tristated data bus holds the stream back instead of dropping it
  logic drain;
  assign drain = Y_OE || !cur_valid;

  vout_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk      (CLK_SYS),
    .nrst     (NRST),
    .in_data  (fifo_in),
    .in_valid (IN_VALID),
    .in_ready (IN_READY),
    .out_data (fifo_out_bits),
    .out_valid(cur_valid),
    .out_ready(drain)
  );

  logic take;
  assign take = cur_valid && drain;

  ////////////////////////////////////////////////////////////////////////////
  // line counting on the output side

  logic [9:0] line_reg;
  logic       hs_prev_reg;
  logic       vs_prev_reg;
  logic [1:0] vlag_cnt_reg;
  logic       vlag_run_reg;

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      hs_prev_reg <= 1'b0;
      vs_prev_reg <= 1'b0;
    end else if (take) begin
      hs_prev_reg <= cur.hsync;
      vs_prev_reg <= cur.vsync;
    end
  end

  logic hs_rise;
  logic vs_rise;
  assign hs_rise = take && cur.hsync && !hs_prev_reg;
  assign vs_rise = take && cur.vsync && !vs_prev_reg;

  // vertical output sync follows the input one three lines later
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      vlag_cnt_reg <= 2'h0;
      vlag_run_reg <= 1'b0;
    end else if (vs_rise) begin
      vlag_cnt_reg <= 2'h0;
      vlag_run_reg <= 1'b1;
    end else if (hs_rise && vlag_run_reg) begin
      vlag_cnt_reg <= vlag_cnt_reg + 2'h1;
      if (vlag_cnt_reg == 2'(VLAG_LINES - 1)) begin
        vlag_run_reg <= 1'b0;
      end
    end
  end

  logic vsync_lagged;
  assign vsync_lagged = vlag_run_reg && hs_rise && (vlag_cnt_reg == 2'(VLAG_LINES - 1));

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      line_reg <= 10'h000;
    end else if (vs_rise) begin
      line_reg <= 10'h001;
    end else if (hs_rise) begin
      line_reg <= line_reg + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line classification

  line_type_t ltype;
  always_comb begin
    ltype = LT_NORMAL;
    if (PALPLUS_MODE) begin
      if (line_reg == LINE_REF_A || line_reg == LINE_REF_B) begin
        ltype = LT_REF;
      end else if (in_range(line_reg, CORE_A_LO, CORE_A_HI) ||
                   in_range(line_reg, CORE_B_LO, CORE_B_HI)) begin
        ltype = LT_CORE;
      end else if (in_range(line_reg, HELP_A_LO, HELP_A_HI) ||
                   in_range(line_reg, HELP_B_LO, HELP_B_HI) ||
                   in_range(line_reg, HELP_C_LO, HELP_C_HI) ||
                   in_range(line_reg, HELP_D_LO, HELP_D_HI)) begin
        ltype = LT_HELPER;
      end
    end
  end

  // helper and reference lines bypass the adaptive comb
  assign COMB_ADAPT_EN = !(ltype == LT_HELPER || ltype == LT_REF);

  ////////////////////////////////////////////////////////////////////////////
  // test pattern generator

  logic [7:0] pix_cnt_reg;
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      pix_cnt_reg <= 8'h00;
    end else if (hs_rise) begin
      pix_cnt_reg <= 8'h00;
    end else if (take) begin
      pix_cnt_reg <= pix_cnt_reg + 8'h01;
    end
  end

  logic [7:0] pat_y;
  logic [7:0] pat_c;
  logic [2:0] bar;
  always_comb begin
    bar = pix_cnt_reg[7:5];
    case (pattern_t'(TEST_PATTERN))
      PAT_RAMP: begin
        pat_y = pix_cnt_reg;
        pat_c = pix_cnt_reg;
      end
      PAT_FLAT: begin
        pat_y = STD_BLACK + (STD_AMPL >> 1);
        pat_c = CHROMA_MID;
      end
      PAT_BAR: begin
        pat_y = STD_BLACK + STD_AMPL - 8'(bar * BAR_STEP);
        pat_c = pix_cnt_reg[0] ? CHROMA_MID + 8'(bar * 8'h0e)
                               : CHROMA_MID - 8'(bar * 8'h0e);
      end
      default: begin
        pat_y = STD_BLACK;
        pat_c = CHROMA_MID;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample selection and code levels

  logic [7:0] y_next;
  logic [7:0] c_next;
  always_comb begin
    // helper lines use the signed scaling shared with chroma; the reference signalling part takes the scaled luma path
    y_next = COMPOSITE_FMT ? scale_luma(cur.luma, CVBS_BLACK, CVBS_AMPL)
                           : scale_luma(cur.luma, STD_BLACK, STD_AMPL);
    c_next = scale_chroma(cur.chroma, CHROMA_SIGNED);
    case (ltype)
      LT_CORE: begin
        y_next = scale_luma(cur.composite, CVBS_BLACK, CVBS_AMPL);
      end
      LT_HELPER: begin
        y_next = scale_signed(cur.helper, HELP_AMPL);
        c_next = 8'h00;
      end
      LT_REF: begin
        if (cur.wss_part) begin
          y_next = scale_luma(cur.helper, WSS_LEVEL, WSS_AMPL);
        end else begin
          y_next = HREF_LEVEL + scale_signed(cur.helper, HREF_AMPL);
        end
        c_next = 8'h00;
      end
      default: begin
      end
    endcase
    if (TEST_MODE) begin
      y_next = pat_y;
      c_next = pat_c;
    end
  end

  logic [7:0] y_reg;
  logic [7:0] c_reg;
  logic       valid_reg;
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      y_reg     <= STD_BLACK;
      c_reg     <= CHROMA_MID;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= take;
      if (take) begin
        y_reg <= y_next;
        c_reg <= c_next;
      end
    end
  end

  // sync latched on the (line-locked) output clock
  logic hs_reg;
  logic vs_reg;
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      hs_reg <= 1'b0;
      vs_reg <= 1'b0;
    end else begin
      hs_reg <= take ? cur.hsync : hs_reg;
      if (vsync_lagged) begin
        vs_reg <= 1'b1;
      end else if (hs_rise) begin
        vs_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  assign Y_OUT     = y_reg;
  assign C_OUT     = c_reg;
  assign HSYNC_OUT = hs_reg;
  assign VSYNC_OUT = vs_reg;
  assign OUT_VALID = valid_reg && Y_OE;
  // enable pin acts combinationally so another source can take the bus at once
  assign Y_OE      = !DATA_TRISTATE && PIXEL_OUTPUT_ENABLE_PIN;
  assign C_OE      = !DATA_TRISTATE && PIXEL_OUTPUT_ENABLE_PIN;
  assign SYNC_OE   = !SYNC_TRISTATE;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  data_gate_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (DATA_TRISTATE || !PIXEL_OUTPUT_ENABLE_PIN) |-> (!Y_OE && !C_OE))
    else $error("data driven while disabled");

  pin_release_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    $fell(PIXEL_OUTPUT_ENABLE_PIN) |-> !Y_OE)
    else $error("enable pin did not release bus");

  sync_tri_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    SYNC_OE == !SYNC_TRISTATE)
    else $error("sync enable wrong");

  comb_off_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (PALPLUS_MODE && in_range(line_reg, HELP_A_LO, HELP_A_HI)) |-> !COMB_ADAPT_EN)
    else $error("comb active on helper line");

  test_pat_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (take && TEST_MODE) |=> (Y_OUT == $past(pat_y)))
    else $error("test pattern not output");

  core_luma_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (take && !TEST_MODE && ltype == LT_CORE) |=> (Y_OUT >= CVBS_BLACK))
    else $error("core line below composite black");

  helper_chroma_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (take && !TEST_MODE && ltype == LT_HELPER) |=> (C_OUT == 8'h00))
    else $error("chroma present on helper line");

  std_black_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (take && !TEST_MODE && ltype == LT_NORMAL && !COMPOSITE_FMT && cur.luma == 8'h00)
      |=> (Y_OUT == STD_BLACK))
    else $error("component black level wrong");

  vs_lag_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    $rose(VSYNC_OUT) |-> ($past(hs_rise) && $past(vlag_cnt_reg) == 2'(VLAG_LINES - 1)))
    else $error("vertical sync not delayed");

endmodule
`default_nettype wire

// ### verilog/vout_pkg.sv
// package: constants and carriers for the video output stage
package vout_pkg;

  // output code levels
  localparam logic [7:0] STD_BLACK    = 8'h10; // 16
  localparam logic [7:0] STD_AMPL     = 8'he0; // 224
  localparam logic [7:0] CVBS_BLACK   = 8'h40; // 64
  localparam logic [7:0] CVBS_AMPL    = 8'h95; // 149
  localparam logic [7:0] CHROMA_MID   = 8'h80; // 128
  localparam logic [7:0] CHROMA_AMPL  = 8'h70; // 112
  localparam logic [7:0] HELP_AMPL    = 8'h6d; // 109
  localparam logic [7:0] WSS_LEVEL    = 8'h44; // 68
  localparam logic [7:0] WSS_AMPL     = 8'h6a; // 106
  localparam logic [7:0] HREF_LEVEL   = 8'h80; // 128
  localparam logic [7:0] HREF_AMPL    = 8'h13; // 19

  // line numbers of the 625 line raster
  localparam logic [9:0] LINE_REF_A   = 10'h017; // 23
  localparam logic [9:0] HELP_A_LO    = 10'h018; // 24
  localparam logic [9:0] HELP_A_HI    = 10'h03b; // 59
  localparam logic [9:0] CORE_A_LO    = 10'h03c; // 60
  localparam logic [9:0] CORE_A_HI    = 10'h112; // 274
  localparam logic [9:0] HELP_B_LO    = 10'h113; // 275
  localparam logic [9:0] HELP_B_HI    = 10'h136; // 310
  localparam logic [9:0] HELP_C_LO    = 10'h150; // 336
  localparam logic [9:0] HELP_C_HI    = 10'h173; // 371
  localparam logic [9:0] CORE_B_LO    = 10'h174; // 372
  localparam logic [9:0] CORE_B_HI    = 10'h24a; // 586
  localparam logic [9:0] HELP_D_LO    = 10'h24b; // 587
  localparam logic [9:0] HELP_D_HI    = 10'h26e; // 622
  localparam logic [9:0] LINE_REF_B   = 10'h26f; // 623

  // vertical lag of outputs behind input, in lines
  localparam int         VLAG_LINES   = 3;
  localparam int         FIFO_DEPTH   = 32;
  localparam logic [7:0] BAR_STEP     = 8'h20;

  typedef enum logic [1:0] {
    PAT_RAMP = 2'b00,
    PAT_FLAT = 2'b01,
    PAT_BAR  = 2'b11
  } pattern_t;

  typedef enum logic [1:0] {
    LT_NORMAL = 2'b00,
    LT_HELPER = 2'b01,
    LT_REF    = 2'b11,
    LT_CORE   = 2'b10
  } line_type_t;

  typedef struct packed {
    logic [7:0] luma;
    logic [7:0] chroma;
    logic [7:0] composite;
    logic [7:0] helper;
    logic       wss_part;
    logic       hsync;
    logic       vsync;
  } sample_t;

  localparam int SAMPLE_W = $bits(sample_t);

endpackage

// ### verilog/vout_fifo.sv
// fifo: buffered sample path with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module vout_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // drain side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             full;
  logic             empty;

  assign empty     = (wr_ptr_reg == rd_ptr_reg);
  assign full      = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                     (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
    end else if (in_valid && !full) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_ptr_reg <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### tb/vout_sink_model.sv
// partner model: downstream back-end that samples the output pins
`timescale 1ns/1ps
`default_nettype none
module vout_sink_model (
  // clock
  input  wire logic       clk,
  // pins from the output stage
  input  wire logic [7:0] y_out,
  input  wire logic       y_oe,
  input  wire logic [7:0] c_out,
  input  wire logic       c_oe,
  input  wire logic       hsync,
  input  wire logic       sync_oe,
  input  wire logic       out_valid
);
  logic [7:0]  alt_reg = 8'h5a;
  logic [16:0] got_q[$];
  // a second source owns the bus while the stage is off; it toggles so stale data shows
  always @(posedge clk) alt_reg <= ~alt_reg;
  always @(posedge clk) begin
    if (out_valid === 1'b1) begin
      got_q.push_back({sync_oe ? hsync : ~hsync, y_oe ? y_out : alt_reg,
                       c_oe ? c_out : ~alt_reg});
    end
  end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// testbench: random and corner-case streams through the video output stage
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vout_pkg::*;
  logic       CLK_SYS = 0, NRST = 0, IN_WSS_PART = 0, IN_HSYNC = 0, IN_VSYNC = 0;
  logic [7:0] IN_LUMA = 0, IN_CHROMA = 0, IN_COMPOSITE = 0, IN_HELPER = 0;
  logic       IN_VALID = 0, DATA_TRISTATE = 0, SYNC_TRISTATE = 0, TEST_MODE = 0;
  logic       PIXEL_OUTPUT_ENABLE_PIN = 1, PALPLUS_MODE = 0, COMPOSITE_FMT = 0;
  logic       CHROMA_SIGNED = 0, IN_READY, COMB_ADAPT_EN, Y_OE, C_OE, SYNC_OE;
  logic       HSYNC_OUT, VSYNC_OUT, OUT_VALID, ph = 0, pv = 0, ih = 0, iv = 0, vso = 0;
  logic [1:0] TEST_PATTERN = PAT_RAMP;
  logic [7:0] Y_OUT, C_OUT;
  logic [19:0] exp_q[$];
  int         failures = 0, num_checks = 0, cur_line = 0, hs_cnt = 0, vs_rises = 0;

  always #25 CLK_SYS = ~CLK_SYS;

  video_output_stage uut (.CLK_SYS(CLK_SYS), .NRST(NRST), .IN_LUMA(IN_LUMA),
    .IN_CHROMA(IN_CHROMA), .IN_COMPOSITE(IN_COMPOSITE), .IN_HELPER(IN_HELPER),
    .IN_WSS_PART(IN_WSS_PART), .IN_HSYNC(IN_HSYNC), .IN_VSYNC(IN_VSYNC),
    .IN_VALID(IN_VALID), .IN_READY(IN_READY), .DATA_TRISTATE(DATA_TRISTATE),
    .SYNC_TRISTATE(SYNC_TRISTATE), .PIXEL_OUTPUT_ENABLE_PIN(PIXEL_OUTPUT_ENABLE_PIN),
    .TEST_MODE(TEST_MODE), .TEST_PATTERN(TEST_PATTERN), .PALPLUS_MODE(PALPLUS_MODE),
    .COMPOSITE_FMT(COMPOSITE_FMT), .CHROMA_SIGNED(CHROMA_SIGNED),
    .COMB_ADAPT_EN(COMB_ADAPT_EN), .Y_OUT(Y_OUT), .Y_OE(Y_OE), .C_OUT(C_OUT),
    .C_OE(C_OE), .HSYNC_OUT(HSYNC_OUT), .VSYNC_OUT(VSYNC_OUT), .SYNC_OE(SYNC_OE),
    .OUT_VALID(OUT_VALID));

  vout_sink_model sink (.clk(CLK_SYS), .y_out(Y_OUT), .y_oe(Y_OE), .c_out(C_OUT),
    .c_oe(C_OE), .hsync(HSYNC_OUT), .sync_oe(SYNC_OE), .out_valid(OUT_VALID));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h got %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    if (failures == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  function automatic line_type_t ltype(int l);
    if (l == 23 || l == 623) return LT_REF;
    if ((l >= 60 && l <= 274) || (l >= 372 && l <= 586)) return LT_CORE;
    if ((l >= 24 && l <= 59) || (l >= 275 && l <= 310) || (l >= 336 && l <= 371) ||
        (l >= 587 && l <= 622)) return LT_HELPER;
    return LT_NORMAL;
  endfunction

  // offset binary code to signed +-a, floor division
  function automatic logic [7:0] sgn_scale(logic [7:0] v, logic [7:0] a);
    return 8'(((int'(v) - int'(CHROMA_MID)) * int'(a)) >>> 7);
  endfunction

  // full-range code onto black..black+a
  function automatic logic [7:0] lin_scale(logic [7:0] v, logic [7:0] b, logic [7:0] a);
    return 8'(int'(b) + ((int'(v) * int'(a)) >> 8));
  endfunction

  // record: flat, luma care, chroma care, hsync, luma, chroma
  function automatic logic [19:0] expect_of(logic care, logic h, logic [7:0] y,
                                            logic [7:0] c, logic [7:0] cp,
                                            logic [7:0] hp, logic w);
    logic [7:0] ey, ec;
    logic       yc, cc;
    ey = COMPOSITE_FMT ? lin_scale(y, CVBS_BLACK, CVBS_AMPL)
                       : lin_scale(y, STD_BLACK, STD_AMPL);
    ec = sgn_scale(c, CHROMA_AMPL) + (CHROMA_SIGNED ? 8'h00 : CHROMA_MID);
    yc = care;
    cc = care;
    case (PALPLUS_MODE ? ltype(cur_line) : LT_NORMAL)
      LT_CORE: ey = lin_scale(cp, CVBS_BLACK, CVBS_AMPL);
      LT_HELPER: begin
        ey = sgn_scale(hp, HELP_AMPL);
        ec = 8'h00;
      end
      LT_REF: begin
        ey = w ? lin_scale(hp, WSS_LEVEL, WSS_AMPL)
               : HREF_LEVEL + sgn_scale(hp, HREF_AMPL);
        ec = 8'h00;
      end
      default: ;
    endcase
    if (TEST_MODE) begin
      yc = 1'b0;
      cc = 1'b0;
    end
    return {TEST_MODE && TEST_PATTERN == PAT_FLAT, yc, cc, h, ey, ec};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  task automatic put(logic h, logic v, logic w, logic [7:0] hp, logic care);
    logic [7:0] y, c, cp;
    int         n;
    // black corner now and then, full code range otherwise
    y = ($urandom % 8 == 0) ? 8'h00 : 8'($urandom);
    c = 8'($urandom);
    cp = 8'($urandom);
    {IN_LUMA, IN_CHROMA, IN_COMPOSITE, IN_HELPER} = {y, c, cp, hp};
    {IN_HSYNC, IN_VSYNC, IN_WSS_PART, IN_VALID} = {h, v, w, 1'b1};
    n = 0;
    while (IN_READY !== 1'b1 && n < 100) begin
      @(posedge CLK_SYS);
      #1;
      n++;
    end
    if (n == 100) check("input ready", IN_READY, 1'b1);
    @(posedge CLK_SYS);
    #1;
    if (v && !pv) cur_line = 1;
    else if (h && !ph) cur_line++;
    {pv, ph} = {v, h};
    if (care) check("comb enable", COMB_ADAPT_EN,
                    !(PALPLUS_MODE && ltype(cur_line) inside {LT_HELPER, LT_REF}));
    exp_q.push_back(expect_of(care, h, y, c, cp, hp, w));
  endtask

  task automatic flush();
    logic [19:0] e;
    logic [16:0] g, gp;
    int          n;
    IN_VALID = 1'b0;
    n = 0;
    while (sink.got_q.size() < exp_q.size() && n < 200) begin
      @(posedge CLK_SYS);
      #1;
      n++;
    end
    check("sample count", sink.got_q.size(), exp_q.size());
    gp = (sink.got_q.size() > 0) ? sink.got_q[0] : 17'h0;
    while (exp_q.size() > 0 && sink.got_q.size() > 0) begin
      e = exp_q.pop_front();
      g = sink.got_q.pop_front();
      check("hsync out", g[16], e[16]);
      if (e[18]) check("luma out", g[15:8], e[15:8]);
      if (e[17]) check("chroma out", g[7:0], e[7:0]);
      if (e[19]) check("flat field", g[15:0], gp[15:0]);
      gp = g;
    end
    exp_q.delete();
    sink.got_q.delete();
  endtask

  // vsync sample, then lines of hsync plus two data samples
  task automatic frame(int lines);
    put(1'b0, 1'b1, 1'b0, 8'($urandom), 1'b0);
    for (int l = 2; l <= lines; l++) begin
      put(1'b1, 1'b0, 1'b0, 8'($urandom), 1'b0);
      put(1'b0, 1'b0, 1'b1, 8'($urandom), 1'b1);
      put(1'b0, 1'b0, 1'b0, CHROMA_MID, 1'b1);
    end
    flush();
    check("vsync count", vs_rises, 1);
    vs_rises = 0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // input-side count of hsync rises since the last vsync rise
  always @(posedge CLK_SYS) begin
    if (VSYNC_OUT === 1'b1 && vso !== 1'b1) begin
      check("vsync lag", hs_cnt, VLAG_LINES);
      vs_rises++;
    end
    vso = VSYNC_OUT;
    if (IN_VALID === 1'b1 && IN_READY === 1'b1) begin
      if (IN_VSYNC && !iv) hs_cnt = 0;
      else if (IN_HSYNC && !ih) hs_cnt++;
      {iv, ih} = {IN_VSYNC, IN_HSYNC};
    end
  end

  initial begin
    #300us;
    failures++;
    stop_test();
  end

  initial begin
    void'($urandom(32'h65be38dc));
    repeat (10) @(posedge CLK_SYS);
    #1;
    check("luma reset", Y_OUT, STD_BLACK);
    check("chroma reset", C_OUT, CHROMA_MID);
    check("sync reset", {HSYNC_OUT, VSYNC_OUT, OUT_VALID}, 3'b000);
    NRST = 1'b1;
    for (int i = 0; i < 8; i++) begin
      {DATA_TRISTATE, PIXEL_OUTPUT_ENABLE_PIN, SYNC_TRISTATE} = 3'(i);
      #1;
      check("data enable", {Y_OE, C_OE},
            {2{!DATA_TRISTATE && PIXEL_OUTPUT_ENABLE_PIN}});
      check("sync enable", SYNC_OE, !SYNC_TRISTATE);
    end
    @(posedge CLK_SYS);
    #1;
    {DATA_TRISTATE, PIXEL_OUTPUT_ENABLE_PIN, SYNC_TRISTATE} = 3'b110;
    // fill the buffer while the bus is off: stalls, nothing leaves
    repeat (FIFO_DEPTH) put(1'b0, 1'b0, 1'b0, 8'($urandom), 1'b1);
    IN_VALID = 1'b0;
    check("buffer full", IN_READY, 1'b0);
    DATA_TRISTATE = 1'b0;
    PIXEL_OUTPUT_ENABLE_PIN = 1'b0;
    repeat (4) @(posedge CLK_SYS);
    #1;
    check("held while pin off", sink.got_q.size(), 0);
    PIXEL_OUTPUT_ENABLE_PIN = 1'b1;
    flush();
    CHROMA_SIGNED = 1'b1;
    COMPOSITE_FMT = 1'b1;
    frame(8);
    CHROMA_SIGNED = 1'($urandom);
    COMPOSITE_FMT = 1'($urandom);
    PALPLUS_MODE = 1'b1;
    frame(625);
    PALPLUS_MODE = 1'b0;
    TEST_MODE = 1'b1;
    for (int k = 0; k < 3; k++) begin
      TEST_PATTERN = (k == 0) ? PAT_RAMP : (k == 1) ? PAT_FLAT : PAT_BAR;
      COMPOSITE_FMT = ~COMPOSITE_FMT;
      repeat (8) put(1'b0, 1'b0, 1'b0, 8'($urandom), 1'b1);
      flush();
    end
    stop_test();
  end
endmodule
`default_nettype wire
